//--- core/timer_cfg.svh
// Constants for the periodic tick timer and cycle tally block
// ----------------------------------------------------------------------
// How it works
// - 32-bit up-counter runs free at 25 MHz
// - Reset forces cycle tally to zero
// - Tally increments exactly once per 25 MHz cycle
// - Tally rolls over from maximum to zero
// - Tally never raises interrupt or status flag
// - Tally may need 160 ns to clear
// - Tally readable at 09Ch, writes ignored
// - Bit 29 runs timer when set, halts when clear
// - Run falling to zero presets preload to FFFFh
// - Preload bits 15:0, read/write, default FFFFh
// - Live current count readable, resets to FFFFh
// - Timer raises first host interrupt after programmed interval, then every 65536 ticks
// - Down-count, wrap to FFFFh, set flag, interrupt
// - Wrap flag sticky, cleared by writing one
// - Each timer decrement spans 100 microseconds
// - Preload write immediately reloads current count
// ----------------------------------------------------------------------
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define TALLY_PERIOD_NS 40
`define TALLY_DIV (`TALLY_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_PERIOD_US 100
`define TICK_DIV (`TICK_PERIOD_US * 1000 / `TALLY_PERIOD_NS)

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define ADDR_W 8
`define OFS_SETUP 8'h8C
`define OFS_CURRENT 8'h90
`define OFS_TALLY 8'h9C
`define OFS_WRAP_STS 8'hA0
`define OFS_WRAP_EN 8'hA4

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define RUN_BIT 29
`define LOAD_MSB 15
`define WRAP_BIT 0
`define LOAD_RST 16'hFFFF
`define CURRENT_RST 16'hFFFF
`define CURRENT_WRAP 16'hFFFF
`define TALLY_RST 32'h0000_0000

`endif

//--- core/timer_pkg.sv
// Types shared by the periodic tick timer and cycle tally block
package timer_pkg;

   typedef enum logic [1:0] {
      RESP_OKAY = 2'h0,
      RESP_SLVERR = 2'h2
   } axi_resp_type;

   typedef enum logic [5:0] {
      SEL_NONE = 6'h01,
      SEL_SETUP = 6'h02,
      SEL_CURRENT = 6'h04,
      SEL_TALLY = 6'h08,
      SEL_STS = 6'h10,
      SEL_EN = 6'h20
   } reg_sel_type;

   typedef struct packed {
      logic [11:0] cnt;
   } presc_state_type;

   typedef struct packed {
      logic [31:0] tally;
      logic run;
      logic [15:0] preload;
      logic [15:0] current;
      logic wrap_flag;
      logic irq_en;
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      axi_resp_type bresp;
      logic rvalid;
      logic [31:0] rdata;
      axi_resp_type rresp;
   } timer_state_type;

endpackage : timer_pkg

//--- core/tick_prescaler.sv
// Enable-pulse divider with synchronous restart
`timescale 1ns/1ps
module tick_prescaler import timer_pkg::*; #(
   parameter logic [11:0] DIVIDE = 12'h004
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic step,
   input wire logic restart,
   output logic pulse
);

   presc_state_type q;
   presc_state_type d;

   // Pulse is suppressed while restarting so a fresh period is whole
   always_comb begin
      d = q;
      pulse = step && !restart && (q.cnt == DIVIDE - 12'h001);
      if (restart) begin
         d.cnt = 12'h000;
      end else if (step) begin
         d.cnt = pulse ? 12'h000 : q.cnt + 12'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : tick_prescaler

//--- core/periodic_timer_top.sv
// Periodic tick timer and free-running cycle tally behind AXI4-Lite
`timescale 1ns/1ps
`include "timer_cfg.svh"
module periodic_timer_top import timer_pkg::*; #(
   parameter logic [11:0] TICK_DIV = 12'(`TICK_DIV)
) (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic TIMER_IRQ
);

   // -------------------------------------------------------------------
   // Decoding
   // -------------------------------------------------------------------
   // Low address bits are ignored: every register is one aligned word
   function automatic reg_sel_type reg_decode(input logic [7:0] addr);
      logic [7:0] word;
      word = {addr[7:2], 2'h0};
      case (word)
         `OFS_SETUP: reg_decode = SEL_SETUP;
         `OFS_CURRENT: reg_decode = SEL_CURRENT;
         `OFS_TALLY: reg_decode = SEL_TALLY;
         `OFS_WRAP_STS: reg_decode = SEL_STS;
         `OFS_WRAP_EN: reg_decode = SEL_EN;
         default: reg_decode = SEL_NONE;
      endcase
   endfunction : reg_decode

   timer_state_type q;
   timer_state_type d;
   logic en25;
   logic tick;
   logic wr_fire;
   logic wr_setup;
   logic sts_clr;
   reg_sel_type wr_sel;
   reg_sel_type rd_sel;
   logic [31:0] wmask;
   logic [31:0] setup_old;
   logic [31:0] setup_new;

   // Write decode stays outside the next-state process: the tick divider
   // restarts on it and its pulse feeds that process, so inside it would
   // close a loop through the process
   assign wr_fire = q.aw_full && q.w_full && !q.bvalid;
   assign wr_sel = reg_decode(q.aw_addr);
   assign wr_setup = wr_fire && (wr_sel == SEL_SETUP) && (|q.w_strb);

   // -------------------------------------------------------------------
   // Rate enables
   // -------------------------------------------------------------------
   // 25 MHz step for the tally, derived from the 100 MHz clock
   tick_prescaler #(
      .DIVIDE(12'(`TALLY_DIV))
   ) tally_div (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .step(1'h1),
      .restart(1'h0),
      .pulse(en25)
   );

   // 100 us tick; restarting on reload or halt keeps the first period
   // after a reload whole instead of a random fraction
   tick_prescaler #(
      .DIVIDE(TICK_DIV)
   ) tick_div (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .step(en25),
      .restart(wr_setup || !q.run),
      .pulse(tick)
   );

   genvar lane;
   generate
      for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
         assign wmask[8*lane+:8] = {8{q.w_strb[lane]}};
      end
   endgenerate

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      d = q;
      rd_sel = reg_decode(S_AXI_ARADDR);
      sts_clr = wr_fire && (wr_sel == SEL_STS) && q.w_strb[0]
         && q.w_data[`WRAP_BIT];
      setup_old = 32'h0000_0000;
      setup_old[`RUN_BIT] = q.run;
      setup_old[`LOAD_MSB:0] = q.preload;
      setup_new = (setup_old & ~wmask) | (q.w_data & wmask);

      // Address and data are taken independently, in either order
      if (S_AXI_AWVALID && !q.aw_full) begin
         d.aw_full = 1'h1;
         d.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !q.w_full) begin
         d.w_full = 1'h1;
         d.w_data = S_AXI_WDATA;
         d.w_strb = S_AXI_WSTRB;
      end
      if (q.bvalid && S_AXI_BREADY) begin
         d.bvalid = 1'h0;
      end

      // Free-running tally; wrap is plain modulo, with no flag
      if (en25) begin
         d.tally = q.tally + 32'h0000_0001;
      end

      // Clear first so that a wrap in the same cycle still sets the flag
      if (sts_clr) begin
         d.wrap_flag = 1'h0;
      end
      if (tick && q.run) begin
         if (q.current == 16'h0000) begin
            d.current = `CURRENT_WRAP;
            d.wrap_flag = 1'h1;
         end else begin
            d.current = q.current - 16'h0001;
         end
      end

      if (wr_fire) begin
         d.aw_full = 1'h0;
         d.w_full = 1'h0;
         d.bvalid = 1'h1;
         d.bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         case (wr_sel)
            SEL_SETUP: begin
               if (|q.w_strb) begin
                  d.run = setup_new[`RUN_BIT];
                  d.preload = setup_new[`LOAD_MSB:0];
                  if (q.run && !setup_new[`RUN_BIT]) begin
                     d.preload = `LOAD_RST;
                  end
                  // Reload wins over a decrement in the same cycle
                  d.current = d.preload;
               end
            end
            SEL_EN: begin
               if (q.w_strb[0]) begin
                  d.irq_en = q.w_data[`WRAP_BIT];
               end
            end
            // Tally and current count are read only
            default: begin
               d.bresp = d.bresp;
            end
         endcase
      end

      if (q.rvalid && S_AXI_RREADY) begin
         d.rvalid = 1'h0;
      end
      if (S_AXI_ARVALID && !q.rvalid) begin
         d.rvalid = 1'h1;
         d.rresp = RESP_OKAY;
         d.rdata = 32'h0000_0000;
         case (rd_sel)
            SEL_SETUP: begin
               d.rdata = setup_old;
            end
            SEL_CURRENT: begin
               d.rdata[15:0] = q.current;
            end
            SEL_TALLY: begin
               d.rdata = q.tally;
            end
            SEL_STS: begin
               d.rdata[`WRAP_BIT] = q.wrap_flag;
            end
            SEL_EN: begin
               d.rdata[`WRAP_BIT] = q.irq_en;
            end
            default: begin
               d.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   // The tally clears as reset asserts, well inside its allowed window
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         q <= '0;
         q.tally <= `TALLY_RST;
         q.preload <= `LOAD_RST;
         q.current <= `CURRENT_RST;
         q.bresp <= RESP_OKAY;
         q.rresp <= RESP_OKAY;
      end else begin
         q <= d;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign S_AXI_AWREADY = !q.aw_full;
   assign S_AXI_WREADY = !q.w_full;
   assign S_AXI_BVALID = q.bvalid;
   assign S_AXI_BRESP = q.bresp;
   assign S_AXI_ARREADY = !q.rvalid;
   assign S_AXI_RVALID = q.rvalid;
   assign S_AXI_RDATA = q.rdata;
   assign S_AXI_RRESP = q.rresp;
   assign TIMER_IRQ = q.wrap_flag && q.irq_en;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);

   sequence seq_setup_wr;
      wr_setup;
   endsequence

   sequence seq_tally_gap;
      !en25 [*3] ##1 en25;
   endsequence

   sequence seq_wrap_hit;
      tick && q.run && (q.current == 16'h0000) && !wr_setup;
   endsequence

   chk_tally_step: assert property (
      en25 |=> q.tally == $past(q.tally) + 32'h0000_0001)
      else $error("tally did not advance by one");

   chk_tally_rate: assert property (
      en25 |=> seq_tally_gap)
      else $error("tally step not at 25 MHz");

   chk_tally_roll: assert property (
      en25 && (q.tally == 32'hFFFF_FFFF) |=> q.tally == 32'h0000_0000)
      else $error("tally did not roll over to zero");

   // Watched on every tally step without a running timer tick, not only at rollover, which runs
   // would never reach
   chk_tally_quiet: assert property (
      en25 && !(tick && q.run) |=> !$rose(q.wrap_flag))
      else $error("tally wrap raised the wrap flag");

   chk_halt_hold: assert property (
      !q.run && !wr_setup |=> $stable(q.current))
      else $error("halted timer changed its count");

   chk_preload_preset: assert property (
      $fell(q.run) |-> q.preload == 16'hFFFF)
      else $error("preload not preset when run cleared");

   chk_wrap_event: assert property (
      seq_wrap_hit |=> q.wrap_flag && (q.current == 16'hFFFF))
      else $error("wrap did not reload and flag");

   chk_flag_sticky: assert property (
      q.wrap_flag && !sts_clr |=> q.wrap_flag)
      else $error("wrap flag dropped without a clear");

   chk_preload_load: assert property (
      seq_setup_wr |=> q.current == q.preload)
      else $error("setup write did not reload the count");

   chk_tick_spacing: assert property (
      tick |=> !tick [*8])
      else $error("timer ticks too close together");

endmodule : periodic_timer_top

//--- tb/periodic_timer_and_cycle_counter_tb.sv
// Self-checking bench for the tick timer and cycle tally block
`timescale 1ns/1ps
`include "timer_cfg.svh"
module periodic_timer_and_cycle_counter_tb import timer_pkg::*;;
   // Timer steps every 4 * TICK_DIV clocks; TICK_DIV is shortened to 4
   localparam int TICK = 16;
   logic clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, br = 0, rr = 0;
   logic awr, wrdy, bv, arr, rv, irq;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rdat, got, v1, p, m;
   logic [3:0] ws = 4'h0;
   logic [1:0] bresp, rresp;
   logic [33:0] e;
   logic [33:0] exq[$];
   logic [31:0] mq[$];
   int errors = 0, compares = 0, cyc = 0, t_ar = 0, t1 = 0, n = 0;

   periodic_timer_top #(.TICK_DIV(12'h004)) u_periodic_timer_top (
      .REF_CLK(clk), .RESET_N(rst_n),
      .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .TIMER_IRQ(irq)
   );

   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   // ------
   // Checking
   // ------
   task automatic chk(string s, logic [31:0] ex, logic [31:0] g);
      compares++;
      if (ex !== g) begin
         errors++;
         $display("mismatch %s exp %h got %h", s, ex, g);
      end
   endtask : chk

   task automatic print_verdict();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   task automatic lim(int k, int b = 60);
      if (k >= b) begin
         errors++;
         print_verdict();
      end
   endtask : lim

   // Oldest note is taken off whenever a response is handed over
   always @(posedge clk) begin
      if (rst_n && ((rv && rr) || (bv && br))) begin
         if (exq.size() == 0) begin
            chk("queue", 1, 0);
         end else begin
            e = exq.pop_front();
            m = mq.pop_front();
            if (rv) chk("rdata", e[31:0], rdat & m);
            chk("resp", 32'(e[33:32]), 32'(rv ? rresp : bresp));
         end
      end
   end

   // ------
   // Bus master
   // ------
   // Ready is raised late at random, so the response must stand
   task automatic wr_reg(logic [7:0] a, logic [31:0] d,
                         logic [3:0] s = 4'hF, logic [1:0] r = 2'h0);
      exq.push_back({r, 32'h0000_0000});
      mq.push_back(32'h0000_0000);
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'($urandom_range(1));
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (awr && awv) awv <= 1'b0;
         if (wrdy && wv) wv <= 1'b0;
         if (!(bv && br)) br <= 1'b1;
      end while (!(bv && br) && n < 60);
      lim(n);
   endtask : wr_reg

   task automatic rd_reg(logic [7:0] a, logic [31:0] ex,
                         logic [31:0] mk = '1, logic [1:0] r = 2'h0);
      exq.push_back({r, ex & mk});
      mq.push_back(mk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'($urandom_range(1));
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (arr && arv) begin
            arv <= 1'b0;
            t_ar = cyc;
         end
         if (rv && rr) got = rdat;
         else rr <= 1'b1;
      end while (!(rv && rr) && n < 60);
      lim(n);
   endtask : rd_reg

   // Two reads whose address phases lie a whole number of steps apart
   task automatic pair(logic [7:0] a, int per, int dir);
      rd_reg(a, 0, 0);
      v1 = got;
      t1 = t_ar;
      while ((cyc + 1 - t1) % per != 0 || cyc + 1 - t1 < 40) @(posedge clk);
      rd_reg(a, 0, 0);
      chk("step", v1 + dir * ((t_ar - t1) / per), got);
   endtask : pair

   // ------
   // Scenarios
   // ------
   initial begin
      void'($urandom(64107));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_reg(`OFS_SETUP, 32'h0000_FFFF);
      rd_reg(`OFS_CURRENT, 32'h0000_FFFF);
      pair(`OFS_TALLY, 4, 1);
      p = $urandom_range(5, 2);
      wr_reg(`OFS_WRAP_EN, 32'h0000_0001);
      wr_reg(`OFS_SETUP, 32'h2000_0000 | p);
      t1 = cyc;
      rd_reg(`OFS_CURRENT, p);
      for (n = 0; !irq && n < 300; n++) @(posedge clk);
      lim(n, 300);
      chk("wrap_gap", 1, 32'((cyc - t1) inside {[16*p+12:16*p+18]}));
      chk("irq", 1, irq);
      rd_reg(`OFS_CURRENT, 32'h0000_FFFF);
      rd_reg(`OFS_WRAP_STS, 32'h0000_0001);
      wr_reg(`OFS_WRAP_STS, 32'h0000_0000);
      rd_reg(`OFS_WRAP_STS, 32'h0000_0001);
      wr_reg(`OFS_WRAP_STS, 32'h0000_0001);
      rd_reg(`OFS_WRAP_STS, 32'h0000_0000);
      chk("irq", 0, irq);
      // Halting presets the preload even though new bits were written
      wr_reg(`OFS_SETUP, 32'h0000_00AB);
      rd_reg(`OFS_SETUP, 32'h0000_FFFF);
      rd_reg(`OFS_CURRENT, 32'h0000_FFFF);
      p = $urandom_range(32'h0000_FFF0, 32'h0000_0001);
      wr_reg(`OFS_SETUP, p);
      repeat (40) @(posedge clk);
      chk("irq", 0, irq);
      rd_reg(`OFS_CURRENT, p);
      rd_reg(`OFS_SETUP, p);
      wr_reg(`OFS_SETUP, 32'h2000_0000, 4'h0);
      wr_reg(`OFS_CURRENT, $urandom());
      wr_reg(`OFS_TALLY, $urandom());
      rd_reg(`OFS_CURRENT, p);
      wr_reg(8'h40, 32'h0000_0001, 4'hF, RESP_SLVERR);
      rd_reg(8'h40, 32'h0000_0000, '1, RESP_SLVERR);
      wr_reg(`OFS_SETUP, 32'h2000_0100);
      pair(`OFS_CURRENT, TICK, -1);
      // Reset in mid-run; low tally bits are left open for the settle time
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(`OFS_TALLY, 32'h0000_0000, 32'hFFFF_FFFC);
      rd_reg(`OFS_SETUP, 32'h0000_FFFF);
      rd_reg(`OFS_CURRENT, 32'h0000_FFFF);
      chk("irq", 0, irq);
      print_verdict();
   end
endmodule : periodic_timer_and_cycle_counter_tb
